// [pmp_pkg.sv]
package pmp_pkg;

    // ------------------------------------------------------------
    // Mode straps and lock sequence
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_HOST_INT = 2'h0;
    localparam logic [1:0] MODE_HOST_EXT = 2'h1;
    localparam logic [1:0] MODE_SAT      = 2'h2;

    localparam logic [1:0] SETTLE_CYC    = 2'h3;

    typedef enum logic [1:0] {
        LK_RESET  = 2'h0,
        LK_SETTLE = 2'h1,
        LK_RUN    = 2'h3
    } pmp_lock_t;

    // ------------------------------------------------------------
    // Sampled pin vector layout
    // ------------------------------------------------------------
    localparam int PIN_W     = 7;
    localparam int PIN_REQ0  = 0;
    localparam int PIN_REQ1  = 1;
    localparam int PIN_GNT0  = 2;
    localparam int PIN_RST   = 3;
    localparam int PIN_SERR  = 4;
    localparam int PIN_STOP  = 5;
    localparam int PIN_TRDY  = 6;

    localparam logic [6:0] PIN_IDLE = 7'h7f;
    localparam logic [1:0] OE_OFF2  = 2'h3;
    localparam logic [1:0] HIGH2    = 2'h3;

endpackage : pmp_pkg

// [pmp_pin_ctrl.sv]
// Contract
// - Host with internal arbiter: both request lines are inputs feeding the arbiter.
// - Host with external arbiter: drive request zero low when bus is needed.
// - Host with external arbiter: request one unused, driven permanently high.
// - Satellite: request zero asks for bus; request one becomes configuration select.
// - Host mode: drive bus reset line to reset PCI agents.
// - Satellite: bus reset line is input; its assertion starts a warm reset.
// - Assert system error on parity or other system errors, open drain.
// - Addressed target asserts stop to end transaction; master honours it.
// - Addressed target asserts target ready when data phase can complete.
// - Grant one is serial memory select in satellite, high with external arbiter.
`timescale 1ns/10ps
module pmp_pin_ctrl
    import pmp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] modeStrap,
    // Request lines
    input  wire logic [1:0] reqIn,
    output logic      [1:0] reqOut,
    output logic      [1:0] reqOeN,
    // Grant lines
    input  wire logic [1:0] gntIn,
    output logic      [1:0] gntOut,
    output logic      [1:0] gntOeN,
    // Bus reset line
    input  wire logic       busRstIn,
    output logic            busRstOut,
    output logic            busRstOeN,
    // System error line, open drain
    input  wire logic       serrIn,
    output logic            serrOut,
    output logic            serrOeN,
    // Target stop and ready lines
    input  wire logic       stopIn,
    output logic            stopOut,
    output logic            stopOeN,
    input  wire logic       trdyIn,
    output logic            trdyOut,
    output logic            trdyOeN,
    // User side
    input  wire logic [1:0] arbGrantN,
    input  wire logic       busNeed,
    input  wire logic       eepromSelN,
    input  wire logic       busResetReq,
    input  wire logic       serrReq,
    input  wire logic       targetSel,
    input  wire logic       stopReq,
    input  wire logic       trdyReq,
    input  wire logic       masterActive,
    output logic      [1:0] arbReqN,
    output logic            gntSeen,
    output logic            configSelect,
    output logic            warmResetPulse,
    output logic            serrSeen,
    output logic            stopSeen,
    output logic            trdySeen,
    output logic            masterEnd,
    output logic      [1:0] modeOut,
    output logic            running
);

    // ------------------------------------------------------------
    // Mode lock
    // ------------------------------------------------------------
    pmp_lock_t   lock_q;
    pmp_lock_t   lock_d;
    logic  [1:0] settle_q;
    logic  [1:0] mode_q;
    logic  [1:0] strapS1_q;
    logic  [1:0] strapS2_q;
    logic  [1:0] strapS3_q;

    // Strap is settled through the same three stages as the pins,
    // then frozen so pin direction cannot flip under live traffic.
    always_comb begin
        case (lock_q)
            LK_RESET:  lock_d = LK_SETTLE;
            LK_SETTLE: lock_d = (settle_q == SETTLE_CYC) ? LK_RUN : LK_SETTLE;
            LK_RUN:    lock_d = LK_RUN;
            default:   lock_d = LK_RESET;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lock_q    <= LK_RESET;
            settle_q  <= 2'h0;
            mode_q    <= MODE_HOST_INT;
            strapS1_q <= MODE_HOST_INT;
            strapS2_q <= MODE_HOST_INT;
            strapS3_q <= MODE_HOST_INT;
        end else begin
            lock_q    <= lock_d;
            strapS1_q <= modeStrap;
            strapS2_q <= strapS1_q;
            strapS3_q <= strapS2_q;
            if (lock_q == LK_SETTLE && settle_q != SETTLE_CYC) begin
                settle_q <= settle_q + 2'h1;
            end
            if (lock_q != LK_RUN && strapS2_q == strapS3_q) begin
                mode_q <= strapS3_q;
            end
        end
    end

    wire run     = (lock_q == LK_RUN);
    wire hostInt = run && (mode_q == MODE_HOST_INT);
    wire hostExt = run && (mode_q == MODE_HOST_EXT);
    wire sat     = run && (mode_q == MODE_SAT);

    // ------------------------------------------------------------
    // Pin input sampling
    // ------------------------------------------------------------
    logic [PIN_W-1:0] pinS1_q;
    logic [PIN_W-1:0] pinS2_q;
    logic [PIN_W-1:0] pinS3_q;
    logic [PIN_W-1:0] filt_q;
    logic             rstPrev_q;

    wire [PIN_W-1:0] pinRaw = {trdyIn, stopIn, serrIn, busRstIn, gntIn[0], reqIn};
    // A bit moves only when stages two and three agree
    wire [PIN_W-1:0] filt_d = (pinS2_q & pinS3_q) | (filt_q & (pinS2_q | pinS3_q));

    always_ff @(posedge clk) begin
        if (rst) begin
            pinS1_q   <= PIN_IDLE;
            pinS2_q   <= PIN_IDLE;
            pinS3_q   <= PIN_IDLE;
            filt_q    <= PIN_IDLE;
            rstPrev_q <= 1'b1;
        end else begin
            pinS1_q   <= pinRaw;
            pinS2_q   <= pinS1_q;
            pinS3_q   <= pinS2_q;
            filt_q    <= filt_d;
            rstPrev_q <= filt_q[PIN_RST];
        end
    end

    // ------------------------------------------------------------
    // Pin drive decode
    // ------------------------------------------------------------
    wire [1:0] reqOeN_d = {~hostExt, ~(hostExt | sat)};
    wire [1:0] reqOut_d = {1'b1, ~busNeed};
    wire [1:0] gntOeN_d = {~run, ~hostInt};
    wire       gnt1Val  = hostInt ? arbGrantN[1] : (sat ? eepromSelN : 1'b1);
    wire [1:0] gntOut_d = {gnt1Val, arbGrantN[0]};
    wire       rstOeN_d = ~(hostInt | hostExt);
    wire       rstOut_d = ~busResetReq;
    wire       serrOeN_d = ~(run & serrReq);
    wire       tgtOeN_d  = ~(run & targetSel);

    // Satellite reset: act on a settled high-to-low move only
    wire warmRst_d = sat & rstPrev_q & ~filt_q[PIN_RST];
    wire stopLow   = ~filt_q[PIN_STOP];

    always_ff @(posedge clk) begin
        if (rst) begin
            reqOut         <= HIGH2;
            reqOeN         <= OE_OFF2;
            gntOut         <= HIGH2;
            gntOeN         <= OE_OFF2;
            busRstOut      <= 1'b1;
            busRstOeN      <= 1'b1;
            serrOut        <= 1'b1;
            serrOeN        <= 1'b1;
            stopOut        <= 1'b1;
            stopOeN        <= 1'b1;
            trdyOut        <= 1'b1;
            trdyOeN        <= 1'b1;
            arbReqN        <= HIGH2;
            gntSeen        <= 1'b0;
            configSelect   <= 1'b0;
            warmResetPulse <= 1'b0;
            serrSeen       <= 1'b0;
            stopSeen       <= 1'b0;
            trdySeen       <= 1'b0;
            masterEnd      <= 1'b0;
            modeOut        <= MODE_HOST_INT;
            running        <= 1'b0;
        end else begin
            reqOut         <= reqOut_d;
            reqOeN         <= reqOeN_d;
            gntOut         <= gntOut_d;
            gntOeN         <= gntOeN_d;
            busRstOut      <= rstOut_d;
            busRstOeN      <= rstOeN_d;
            serrOut        <= 1'b0;
            serrOeN        <= serrOeN_d;
            stopOut        <= ~stopReq;
            stopOeN        <= tgtOeN_d;
            trdyOut        <= ~trdyReq;
            trdyOeN        <= tgtOeN_d;
            arbReqN        <= hostInt ? filt_q[1:0] : HIGH2;
            gntSeen        <= (hostExt | sat) & ~filt_q[PIN_GNT0];
            configSelect   <= sat & ~filt_q[PIN_REQ1];
            warmResetPulse <= warmRst_d;
            serrSeen       <= run & ~filt_q[PIN_SERR];
            stopSeen       <= run & stopLow;
            trdySeen       <= run & ~filt_q[PIN_TRDY];
            masterEnd      <= run & masterActive & stopLow;
            modeOut        <= mode_q;
            running        <= run;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence sFallSeen;
        ##1 (sat && rstPrev_q && !filt_q[PIN_RST]);
    endsequence

    a_req_inputs: assert property (@(posedge clk) disable iff (rst)
        hostInt |=> (reqOeN == 2'h3 && arbReqN == $past(filt_q[1:0])))
        else $error("request lines not inputs with internal arbiter");

    a_req0_drive: assert property (@(posedge clk) disable iff (rst)
        (hostExt || sat) |=> (!reqOeN[0] && reqOut[0] == !$past(busNeed)))
        else $error("request zero not driven from bus need");

    a_req1_high: assert property (@(posedge clk) disable iff (rst)
        hostExt |=> (!reqOeN[1] && reqOut[1]))
        else $error("request one not held high");

    a_cfg_select: assert property (@(posedge clk) disable iff (rst)
        sat |=> (reqOeN[1] && configSelect == !$past(filt_q[PIN_REQ1])))
        else $error("config select not taken from request one");

    a_rst_drive: assert property (@(posedge clk) disable iff (rst)
        (hostInt || hostExt) |=> (!busRstOeN && busRstOut == !$past(busResetReq)))
        else $error("bus reset not driven in host mode");

    a_warm_pulse: assert property (@(posedge clk) disable iff (rst)
        sFallSeen |=> (warmResetPulse ##1 !warmResetPulse))
        else $error("warm reset pulse wrong");

    a_serr_od: assert property (@(posedge clk) disable iff (rst)
        (run && serrReq) |=> (!serrOeN && !serrOut))
        else $error("system error not pulled low");

    a_stop_end: assert property (@(posedge clk) disable iff (rst)
        (run && masterActive && !filt_q[PIN_STOP]) |=> masterEnd)
        else $error("master ignored stop");

    a_trdy_drive: assert property (@(posedge clk) disable iff (rst)
        (run && targetSel && trdyReq) |=> (!trdyOeN && !trdyOut))
        else $error("target ready not driven");

    a_gnt1_use: assert property (@(posedge clk) disable iff (rst)
        (sat |=> gntOut[1] == $past(eepromSelN)) and (hostExt |=> gntOut[1]))
        else $error("grant one function wrong");

    a_mode_frozen: assert property (@(posedge clk) disable iff (rst)
        run |=> ($stable(mode_q) && running))
        else $error("mode changed while running");

endmodule : pmp_pin_ctrl

// [pmp_far_agent.sv]
`timescale 1ns/10ps
module pmp_far_agent
    import pmp_pkg::*;
(
    input  wire logic [1:0] reqOut,
    input  wire logic [1:0] reqOeN,
    input  wire logic [1:0] gntOut,
    input  wire logic [1:0] gntOeN,
    input  wire logic       busRstOut,
    input  wire logic       busRstOeN,
    input  wire logic       serrOut,
    input  wire logic       serrOeN,
    input  wire logic       stopOut,
    input  wire logic       stopOeN,
    input  wire logic       trdyOut,
    input  wire logic       trdyOeN,
    input  wire logic [1:0] agReqN,
    input  wire logic [1:0] agGntN,
    input  wire logic       agRstN,
    input  wire logic       agSerrN,
    input  wire logic       agStopN,
    input  wire logic       agTrdyN,
    output logic      [1:0] reqIn,
    output logic      [1:0] gntIn,
    output logic            busRstIn,
    output logic            serrIn,
    output logic            stopIn,
    output logic            trdyIn
);
    // ------------------------------------------------------------
    // Wire resolution, all lines pulled up
    // ------------------------------------------------------------
    // Agents only ever pull low, so a released line reads high
    assign reqIn    = (reqOut | reqOeN) & agReqN;
    assign gntIn    = (gntOut | gntOeN) & agGntN;
    assign busRstIn = (busRstOut | busRstOeN) & agRstN;
    assign serrIn   = (serrOut | serrOeN) & agSerrN;
    assign stopIn   = (stopOut | stopOeN) & agStopN;
    assign trdyIn   = (trdyOut | trdyOeN) & agTrdyN;
endmodule : pmp_far_agent

// [test_pmp_pin_ctrl.sv]
`timescale 1ns/10ps
module test_pmp_pin_ctrl
    import pmp_pkg::*;
;
    logic       clk, rst, busNeed, eepromSelN, busResetReq, serrReq, targetSel;
    logic       stopReq, trdyReq, masterActive, agRstN, agSerrN, agStopN, agTrdyN;
    logic [1:0] modeStrap, arbGrantN, agReqN, agGntN;
    wire  [1:0] reqIn, reqOut, reqOeN, gntIn, gntOut, gntOeN, arbReqN, modeOut;
    wire        busRstIn, busRstOut, busRstOeN, serrIn, serrOut, serrOeN;
    wire        stopIn, stopOut, stopOeN, trdyIn, trdyOut, trdyOeN, gntSeen;
    wire        configSelect, warmResetPulse, serrSeen, stopSeen, trdySeen;
    wire        masterEnd, running;
    int         errors = 0;
    int         num_checks = 0;
    int         pulses;

    pmp_pin_ctrl uut (.clk, .rst, .modeStrap, .reqIn, .reqOut, .reqOeN, .gntIn,
        .gntOut, .gntOeN, .busRstIn, .busRstOut, .busRstOeN, .serrIn, .serrOut,
        .serrOeN, .stopIn, .stopOut, .stopOeN, .trdyIn, .trdyOut, .trdyOeN,
        .arbGrantN, .busNeed, .eepromSelN, .busResetReq, .serrReq, .targetSel,
        .stopReq, .trdyReq, .masterActive, .arbReqN, .gntSeen, .configSelect,
        .warmResetPulse, .serrSeen, .stopSeen, .trdySeen, .masterEnd, .modeOut,
        .running);
    pmp_far_agent agent (.reqOut, .reqOeN, .gntOut, .gntOeN, .busRstOut,
        .busRstOeN, .serrOut, .serrOeN, .stopOut, .stopOeN, .trdyOut, .trdyOeN,
        .agReqN, .agGntN, .agRstN, .agSerrN, .agStopN, .agTrdyN, .reqIn, .gntIn,
        .busRstIn, .serrIn, .stopIn, .trdyIn);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Leaves us just after an edge, where registered outputs have settled
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task summarize();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    // Mode is only taken at reset, so every mode needs a fresh reset
    task startMode(input logic [1:0] m);
        @(posedge clk);
        rst       <= 1'b1;
        modeStrap <= m;
        cyc(20);
        check("oeReset", {reqOeN, gntOeN, busRstOeN, serrOeN, stopOeN, trdyOeN}, 8'hff);
        @(posedge clk);
        rst <= 1'b0;
        cyc(8);
        check("running", running, 8'h01);
        check("modeOut", modeOut, m);
    endtask : startMode

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task testHostInt();
        startMode(MODE_HOST_INT);
        check("reqOeN", reqOeN, 8'h03);
        @(posedge clk);
        agReqN      <= 2'h1;
        busResetReq <= 1'b1;
        arbGrantN   <= 2'h2;
        cyc(1);
        check("busRst", {busRstOut, busRstOeN}, 8'h00);
        check("gnt", {gntOut, gntOeN}, 8'h08);
        cyc(5);
        check("arbReqN", arbReqN, 8'h01);
        @(posedge clk);
        agReqN      <= 2'h3;
        busResetReq <= 1'b0;
        arbGrantN   <= 2'h3;
        $display("test hostInt done");
    endtask : testHostInt

    task testHostExt();
        startMode(MODE_HOST_EXT);
        @(posedge clk);
        busNeed <= 1'b1;
        agGntN  <= 2'h2;
        cyc(1);
        check("req", {reqOut, reqOeN}, 8'h08);
        check("gnt1", {gntOut[1], gntOeN}, 8'h05);
        cyc(5);
        check("gntSeen", gntSeen, 8'h01);
        check("arbReqN", arbReqN, 8'h03);
        @(posedge clk);
        busNeed <= 1'b0;
        agGntN  <= 2'h3;
        cyc(1);
        check("req0Off", reqOut[0], 8'h01);
        $display("test hostExt done");
    endtask : testHostExt

    task testSat();
        startMode(MODE_SAT);
        @(posedge clk);
        busNeed     <= 1'b1;
        eepromSelN  <= 1'b0;
        agReqN      <= 2'h1;
        busResetReq <= 1'b1;
        modeStrap   <= MODE_HOST_INT;
        cyc(1);
        check("req", {reqOut[0], reqOeN}, 8'h02);
        check("eeSel", {gntOut[1], gntOeN[1]}, 8'h00);
        check("busRstOeN", busRstOeN, 8'h01);
        cyc(5);
        check("configSelect", configSelect, 8'h01);
        @(posedge clk);
        agRstN <= 1'b0;
        pulses = 0;
        repeat (12) begin
            cyc(1);
            pulses += int'(warmResetPulse);
        end
        check("warmPulses", pulses[7:0], 8'h01);
        check("modeHeld", modeOut, MODE_SAT);
        @(posedge clk);
        busNeed     <= 1'b0;
        eepromSelN  <= 1'b1;
        agReqN      <= 2'h3;
        busResetReq <= 1'b0;
        agRstN      <= 1'b1;
        $display("test sat done");
    endtask : testSat

    task testCommon();
        @(posedge clk);
        serrReq   <= 1'b1;
        targetSel <= 1'b1;
        stopReq   <= 1'b1;
        trdyReq   <= 1'b1;
        cyc(1);
        check("serr", {serrOut, serrOeN}, 8'h00);
        check("stopTrdy", {stopOut, stopOeN, trdyOut, trdyOeN}, 8'h00);
        cyc(5);
        check("seen", {serrSeen, stopSeen, trdySeen}, 8'h07);
        @(posedge clk);
        serrReq      <= 1'b0;
        targetSel    <= 1'b0;
        agSerrN      <= 1'b0;
        agStopN      <= 1'b0;
        masterActive <= 1'b1;
        cyc(1);
        check("released", {serrOeN, stopOeN, trdyOeN}, 8'h07);
        cyc(6);
        check("farSeen", {serrSeen, stopSeen, trdySeen, masterEnd}, 8'h0d);
        @(posedge clk);
        agStopN <= 1'b1;
        cyc(6);
        check("masterEnd", masterEnd, 8'h00);
        $display("test common done");
    endtask : testCommon

    // Unused strap code: no request or bus reset pin is claimed, whatever the user side asks; grant one is driven high
    task testNoMode();
        startMode(2'h3);
        @(posedge clk);
        busNeed     <= 1'b1;
        busResetReq <= 1'b1;
        agReqN      <= 2'h0;
        agGntN      <= 2'h0;
        cyc(5);
        check("noModeOe", {reqOeN, gntOeN, busRstOeN, gntOut[1]}, 8'h37);
        check("noModeSeen", {arbReqN, gntSeen, configSelect}, 8'h0c);
        @(posedge clk);
        busNeed     <= 1'b0;
        busResetReq <= 1'b0;
        agReqN      <= 2'h3;
        agGntN      <= 2'h3;
        $display("test noMode done");
    endtask : testNoMode

    // ------------------------------------------------------------
    // Clock, main sequence, watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        {rst, busNeed, busResetReq, serrReq, targetSel, stopReq, trdyReq} = 7'h40;
        {masterActive, eepromSelN, agRstN, agSerrN, agStopN, agTrdyN} = 6'h1f;
        {modeStrap, arbGrantN, agReqN, agGntN} = 8'h3f;
        testHostInt();
        testHostExt();
        testSat();
        testCommon();
        testNoMode();
        summarize();
    end

    // Whole run is under two hundred and twenty cycles; this is far beyond it
    initial begin
        #(25 * 4000);
        errors++;
        summarize();
    end
endmodule : test_pmp_pin_ctrl
